// *** dual_clock_byte_fifo.sv ***
// Top of the byte buffer with separately clocked write and read ports
`timescale 1ns/10ps
`include "byte_fifo_params.svh"
// Overview of operation
// RL1 - Write and read data are eight bits
// RL2 - Reset returns both pointers to start
// RL3 - System resets the buffer before first write
// RL4 - Reset drives full flags high
// RL5 - Reset drives empty flags low
// RL6 - Reset clears output register to zero
// RL7 - Enabled write edge stores byte sequentially
// RL8 - Write disabled stores nothing
// RL9 - Full holds flag low, ignores writes
// RL10 - Read frees space, full flag releases
// RL11 - Full flags change on write edges only
// RL12 - Enabled read edge loads oldest byte
// RL13 - Read disabled keeps output register
// RL14 - Empty holds flag low, ignores reads
// RL15 - Write into empty releases empty flag
// RL16 - Empty flags change on read edges only
// RL17 - Works with unrelated or shared clocks
// RL18 - Output enable drives or floats bus
// RL19 - Empty when read and write pointers match
// RL20 - Full when count equals depth
// RL21 - Almost full at depth minus seven
// RL22 - Almost empty at seven or fewer
// RL23 - Port clocks cross through multi-stage synchronisers
// RL24 - Depth is power-of-two parameter, thresholds derived
module dual_clock_byte_fifo
  import byte_fifo_pkg::*;
#(
  parameter int DEPTH = `FIFO_DEPTH
)
(
  // Clock and reset
  input  wire  logic                   CLK_IN,
  input  wire  logic                   RST_IN,
  input  wire  logic                   RESET_N_IN,
  // Write port
  input  wire  logic                   WR_CLK_IN,
  input  wire  logic                   WR_EN_N_IN,
  input  wire  logic [`FIFO_WIDTH-1:0] WR_DATA_IN,
  // Read port
  input  wire  logic                   RD_CLK_IN,
  input  wire  logic                   RD_EN_N_IN,
  input  wire  logic                   OUT_EN_N_IN,
  output logic       [`FIFO_WIDTH-1:0] RD_DATA_OUT,
  output logic                         RD_DATA_OE_OUT,
  // Status flags
  output logic                         FULL_N_OUT,
  output logic                         ALMOST_FULL_N_OUT,
  output logic                         EMPTY_N_OUT,
  output logic                         ALMOST_EMPTY_N_OUT
);
  localparam int             CW      = $clog2(DEPTH) + 1;
  localparam int             LAST    = `SYNC_STAGES - 1;
  localparam int             MARGIN  = `FLAG_MARGIN;
  localparam int             RSF_CYC = `RESET_TO_FLAG_CYCLES;
  localparam logic [CW-1:0]  FULL_CNT = CW'(DEPTH);              // RL24
  localparam logic [CW-1:0]  AF_CNT   = CW'(DEPTH - MARGIN);     // RL24
  localparam logic [CW-1:0]  AE_CNT   = CW'(MARGIN);             // RL24

  typedef struct packed {
    wr_port_type [`SYNC_STAGES-1:0] wr_sync;
    rd_port_type [`SYNC_STAGES-1:0] rd_sync;
    logic        [`SYNC_STAGES-1:0] rst_sync;
    logic                           wr_clk_level;
    logic                           rd_clk_level;
    logic                           rst_level;
    logic                           full_n;
    logic                           almost_full_n;
    logic                           empty_n;
    logic                           almost_empty_n;
    byte_type                       rd_data;
    logic                           out_drive;
  } state_type;

  state_type    st;
  state_type    next_st;
  wr_port_type  wr_pin;
  rd_port_type  rd_pin;
  logic         wr_agree;
  logic         rd_agree;
  logic         wr_edge;
  logic         rd_edge;
  logic         reset_active;
  logic         push_fire;
  logic         pop_fire;
  logic [CW-1:0] next_count;

  fifo_link_if #(.WIDTH(`FIFO_WIDTH), .DEPTH(DEPTH)) lnk ();

  byte_store #(
    .WIDTH (`FIFO_WIDTH),
    .DEPTH (DEPTH)
  ) u_store (
    .clk_in (CLK_IN),
    .rst_in (RST_IN),
    .link   (lnk.store)
  );

  // Port pins travel with their clock through the same stages
  assign wr_pin       = {WR_CLK_IN, WR_EN_N_IN, WR_DATA_IN};                // RL1
  assign rd_pin       = {RD_CLK_IN, RD_EN_N_IN, OUT_EN_N_IN};
  assign wr_agree     = (st.wr_sync[LAST-1].clk == st.wr_sync[LAST].clk);   // RL23
  assign rd_agree     = (st.rd_sync[LAST-1].clk == st.rd_sync[LAST].clk);   // RL23
  assign wr_edge      = wr_agree && st.wr_sync[LAST].clk && !st.wr_clk_level; // RL17
  assign rd_edge      = rd_agree && st.rd_sync[LAST].clk && !st.rd_clk_level; // RL17
  assign reset_active = !st.rst_level;

  // Requests into the storage
  assign lnk.flush      = reset_active;                                      // RL2
  assign lnk.push_valid = wr_edge && !st.wr_sync[LAST].en_n                  // RL8
                          && st.full_n && !reset_active;                     // RL9
  assign lnk.push_data  = st.wr_sync[LAST].data;
  assign lnk.pop_ready  = rd_edge && !st.rd_sync[LAST].en_n                  // RL13
                          && st.empty_n && !reset_active;                    // RL14
  assign push_fire      = lnk.push_valid && lnk.push_ready;
  assign pop_fire       = lnk.pop_valid && lnk.pop_ready;
  assign next_count     = lnk.count + CW'(push_fire) - CW'(pop_fire);

  always_comb
  begin
    next_st          = st;
    next_st.wr_sync  = {st.wr_sync[LAST-1:0], wr_pin};
    next_st.rd_sync  = {st.rd_sync[LAST-1:0], rd_pin};
    next_st.rst_sync = {st.rst_sync[LAST-1:0], RESET_N_IN};
    if (wr_agree)
      next_st.wr_clk_level = st.wr_sync[LAST].clk;
    if (rd_agree)
      next_st.rd_clk_level = st.rd_sync[LAST].clk;
    if (st.rst_sync[LAST-1] == st.rst_sync[LAST])
      next_st.rst_level = st.rst_sync[LAST];
    if (st.rd_sync[LAST-1].oe_n == st.rd_sync[LAST].oe_n)
      next_st.out_drive = !st.rd_sync[LAST].oe_n;                            // RL18
    if (reset_active)
    begin
      next_st.full_n         = `FULL_N_RESET;                                // RL4
      next_st.almost_full_n  = `ALMOST_FULL_N_RESET;                         // RL4
      next_st.empty_n        = `EMPTY_N_RESET;                               // RL5
      next_st.almost_empty_n = `ALMOST_EMPTY_N_RESET;                        // RL5
      next_st.rd_data        = `RD_DATA_RESET;                               // RL6
    end
    else
    begin
      if (wr_edge)  // RL11
      begin
        next_st.full_n        = (next_count != FULL_CNT);                    // RL10 RL20
        next_st.almost_full_n = (next_count < AF_CNT);                       // RL21
      end
      if (rd_edge)  // RL16
      begin
        next_st.empty_n        = (next_count != '0);                         // RL15 RL19
        next_st.almost_empty_n = (next_count > AE_CNT);                      // RL22
      end
      if (pop_fire)
        next_st.rd_data = lnk.pop_data;                                      // RL12
    end
  end

  always_ff @(posedge CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      st                <= '0;
      st.full_n         <= `FULL_N_RESET;
      st.almost_full_n  <= `ALMOST_FULL_N_RESET;
      st.empty_n        <= `EMPTY_N_RESET;
      st.almost_empty_n <= `ALMOST_EMPTY_N_RESET;
      st.rd_data        <= `RD_DATA_RESET;
      st.out_drive      <= `OUT_DRIVE_RESET;
    end
    else
      st <= next_st;
  end

  // Outputs straight from state
  assign RD_DATA_OUT        = st.rd_data;
  assign RD_DATA_OE_OUT     = st.out_drive;
  assign FULL_N_OUT         = st.full_n;
  assign ALMOST_FULL_N_OUT  = st.almost_full_n;
  assign EMPTY_N_OUT        = st.empty_n;
  assign ALMOST_EMPTY_N_OUT = st.almost_empty_n;

  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (RST_IN);

  sequence s_write_req;
    wr_edge && !st.wr_sync[LAST].en_n && st.full_n && !reset_active;
  endsequence

  sequence s_read_req;
    rd_edge && !st.rd_sync[LAST].en_n && st.empty_n && !reset_active;
  endsequence

  property p_reset_full_flags;
    reset_active |-> ##[1:RSF_CYC] (FULL_N_OUT && ALMOST_FULL_N_OUT);
  endproperty
  a_reset_full_flags: assert property (p_reset_full_flags) // RL4
    else $error("Full flags not high after reset");

  property p_reset_empty_flags;
    reset_active |-> ##[1:RSF_CYC] (!EMPTY_N_OUT && !ALMOST_EMPTY_N_OUT);
  endproperty
  a_reset_empty_flags: assert property (p_reset_empty_flags) // RL5
    else $error("Empty flags not low after reset");

  property p_reset_clears_output;
    reset_active |=> (RD_DATA_OUT == `RD_DATA_RESET) && (lnk.count == '0);
  endproperty
  a_reset_clears_output: assert property (p_reset_clears_output) // RL6
    else $error("Reset left data or pointers set");

  property p_full_blocks_write;
    !FULL_N_OUT && !reset_active |-> !lnk.push_valid ##1
      (lnk.count == $past(lnk.count) - CW'($past(pop_fire)));
  endproperty
  a_full_blocks_write: assert property (p_full_blocks_write) // RL9
    else $error("Write taken while full");

  property p_write_stored;
    s_write_req and !lnk.pop_ready |=> (lnk.count == $past(lnk.count) + 1'b1);
  endproperty
  a_write_stored: assert property (p_write_stored) // RL7
    else $error("Enabled write did not store a byte");

  property p_read_loads_oldest;
    s_read_req |=> (RD_DATA_OUT == $past(lnk.pop_data));
  endproperty
  a_read_loads_oldest: assert property (p_read_loads_oldest) // RL12
    else $error("Read did not load the oldest byte");

  property p_hold_output;
    !pop_fire && !reset_active |=> $stable(RD_DATA_OUT);
  endproperty
  a_hold_output: assert property (p_hold_output) // RL13
    else $error("Output register changed without a read");

  property p_write_flags_on_edge;
    !wr_edge && !reset_active |=> $stable(FULL_N_OUT) && $stable(ALMOST_FULL_N_OUT);
  endproperty
  a_write_flags_on_edge: assert property (p_write_flags_on_edge) // RL11
    else $error("Full flags moved off a write edge");

  property p_read_flags_on_edge;
    !rd_edge && !reset_active |=> $stable(EMPTY_N_OUT) && $stable(ALMOST_EMPTY_N_OUT);
  endproperty
  a_read_flags_on_edge: assert property (p_read_flags_on_edge) // RL16
    else $error("Empty flags moved off a read edge");

  property p_empty_when_equal;
    rd_edge && !reset_active |=> (EMPTY_N_OUT == ($past(next_count) != '0));
  endproperty
  a_empty_when_equal: assert property (p_empty_when_equal) // RL19
    else $error("Empty flag does not match pointer equality");

  property p_full_at_depth;
    wr_edge && !reset_active |=> (FULL_N_OUT == ($past(next_count) != FULL_CNT));
  endproperty
  a_full_at_depth: assert property (p_full_at_depth) // RL20
    else $error("Full flag does not match depth");

  property p_almost_full;
    wr_edge && !reset_active |=> (ALMOST_FULL_N_OUT == ($past(next_count) < AF_CNT));
  endproperty
  a_almost_full: assert property (p_almost_full) // RL21
    else $error("Almost full flag wrong");

  property p_almost_empty;
    rd_edge && !reset_active |=> (ALMOST_EMPTY_N_OUT == ($past(next_count) > AE_CNT));
  endproperty
  a_almost_empty: assert property (p_almost_empty) // RL22
    else $error("Almost empty flag wrong");

  property p_output_drive;
    (st.rd_sync[LAST-1].oe_n == st.rd_sync[LAST].oe_n) |=>
      (RD_DATA_OE_OUT == !$past(st.rd_sync[LAST].oe_n));
  endproperty
  a_output_drive: assert property (p_output_drive) // RL18
    else $error("Output drive does not follow output enable");

  sequence s_idle_write;
    wr_edge && st.wr_sync[LAST].en_n && !lnk.pop_ready && !reset_active;
  endsequence

  sequence s_read_when_empty;
    rd_edge && !st.rd_sync[LAST].en_n && !EMPTY_N_OUT && !reset_active;
  endsequence

  property p_write_disabled;
    s_idle_write |=> $stable(lnk.count);
  endproperty
  a_write_disabled: assert property (p_write_disabled) // RL8
    else $error("Write taken with the write enable off");

  property p_empty_blocks_read;
    s_read_when_empty |=> $stable(RD_DATA_OUT) && (lnk.count >= $past(lnk.count));
  endproperty
  a_empty_blocks_read: assert property (p_empty_blocks_read) // RL14
    else $error("Read taken while empty");

  property p_full_release;
    !FULL_N_OUT && pop_fire && wr_edge && !reset_active |=> FULL_N_OUT;
  endproperty
  a_full_release: assert property (p_full_release) // RL10
    else $error("Full flag held after a read freed space");

  property p_empty_release;
    !EMPTY_N_OUT && push_fire && rd_edge && !reset_active |=> EMPTY_N_OUT;
  endproperty
  a_empty_release: assert property (p_empty_release) // RL15
    else $error("Empty flag held after a write");
endmodule // dual_clock_byte_fifo

// *** byte_fifo_params.svh ***
// Constants of the dual port byte buffer
`ifndef BYTE_FIFO_PARAMS_SVH
`define BYTE_FIFO_PARAMS_SVH

`define FIFO_WIDTH              8
`define FIFO_DEPTH              64
`define STAGE_DEPTH             8
`define FLAG_MARGIN             7
`define SYNC_STAGES             3

`define FULL_N_RESET            1'b1
`define ALMOST_FULL_N_RESET     1'b1
`define EMPTY_N_RESET           1'b0
`define ALMOST_EMPTY_N_RESET    1'b0
`define RD_DATA_RESET           8'h00
`define OUT_DRIVE_RESET         1'b0

`define CLK_PERIOD_NS           50
`define RESET_TO_FLAG_DELAY_NS  10
`define RESET_TO_FLAG_CYCLES \
  (((`RESET_TO_FLAG_DELAY_NS) / (`CLK_PERIOD_NS)) > 0 ? \
   ((`RESET_TO_FLAG_DELAY_NS) / (`CLK_PERIOD_NS)) : 1)

`endif

// *** byte_fifo_pkg.sv ***
// Shared types of the dual port byte buffer
`include "byte_fifo_params.svh"
package byte_fifo_pkg;
  typedef logic [`FIFO_WIDTH-1:0] byte_type;

  typedef struct packed {
    logic     clk;
    logic     en_n;
    byte_type data;
  } wr_port_type;

  typedef struct packed {
    logic clk;
    logic en_n;
    logic oe_n;
  } rd_port_type;
endpackage

// *** fifo_link_if.sv ***
// Handshake link between the port logic and the storage
`timescale 1ns/10ps
interface fifo_link_if #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
);
  logic                     flush;
  logic                     push_valid;
  logic                     push_ready;
  logic [WIDTH-1:0]         push_data;
  logic                     pop_valid;
  logic                     pop_ready;
  logic [WIDTH-1:0]         pop_data;
  logic [$clog2(DEPTH):0]   count;

  modport store (
    input  flush,
    input  push_valid,
    input  push_data,
    input  pop_ready,
    output push_ready,
    output pop_valid,
    output pop_data,
    output count
  );

  modport user (
    output flush,
    output push_valid,
    output push_data,
    output pop_ready,
    input  push_ready,
    input  pop_valid,
    input  pop_data,
    input  count
  );
endinterface : fifo_link_if

// *** byte_store.sv ***
// Parameterised first-in first-out storage with valid and ready on both sides
`timescale 1ns/10ps
`include "byte_fifo_params.svh"
module byte_store
  import byte_fifo_pkg::*;
#(
  parameter int WIDTH = `FIFO_WIDTH,
  parameter int DEPTH = `STAGE_DEPTH
)
(
  // Clock and reset
  input  wire logic   clk_in,
  input  wire logic   rst_in,
  // Link to the port logic
  fifo_link_if.store  link
);
  localparam int           AW   = $clog2(DEPTH);
  localparam logic [AW:0]  FULL = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr_ptr;
    logic [AW-1:0]               rd_ptr;
    logic [AW:0]                 count;
  } store_type;

  store_type st;
  store_type next_st;
  logic      push_fire;
  logic      pop_fire;

  assign link.push_ready = (st.count != FULL);
  assign link.pop_valid  = (st.count != '0);
  assign link.pop_data   = st.mem[st.rd_ptr];
  assign link.count      = st.count;
  assign push_fire       = link.push_valid && link.push_ready;
  assign pop_fire        = link.pop_valid && link.pop_ready;

  always_comb
  begin
    next_st = st;
    if (link.flush)
    begin
      next_st.wr_ptr = '0; // RL2
      next_st.rd_ptr = '0; // RL2
      next_st.count  = '0;
    end
    else
    begin
      if (push_fire)
      begin
        next_st.mem[st.wr_ptr] = link.push_data; // RL7
        next_st.wr_ptr         = st.wr_ptr + 1'b1;
      end
      if (pop_fire)
      begin
        next_st.rd_ptr = st.rd_ptr + 1'b1;
      end
      next_st.count = st.count + (AW+1)'(push_fire) - (AW+1)'(pop_fire);
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      st <= '0;
    else
      st <= next_st;
  end

  property p_count_bounded;
    @(posedge clk_in) disable iff (rst_in)
    push_fire && !pop_fire && !link.flush |=> (st.count == $past(st.count) + 1'b1)
      && (st.count <= FULL);
  endproperty
  a_count_bounded: assert property (p_count_bounded) // RL24
    else $error("Storage count did not follow an accepted push");
endmodule // byte_store

// *** port_side_model.sv ***
// Model of the writing and reading system logic on the two port clocks
`timescale 1ns/10ps
module port_side_model
(
  // System clock
  input  wire logic       clk_in,
  // Write side
  output logic            wr_clk_out,
  output logic            wr_en_n_out,
  output logic [7:0]      wr_data_out,
  // Read side
  output logic            rd_clk_out,
  output logic            rd_en_n_out
);
  initial
  begin
    wr_clk_out  = 1'b0;
    rd_clk_out  = 1'b0;
    wr_en_n_out = 1'b1;
    rd_en_n_out = 1'b1;
    wr_data_out = 8'h00;
  end

  // One port cycle; the read rise trails the write rise by skew cycles
  task automatic port_cycle(input logic dw, input logic dr, input logic wen_n,
                            input logic ren_n, input logic [7:0] d, input int skew);
    @(negedge clk_in);
    wr_en_n_out = wen_n;
    wr_data_out = d;
    rd_en_n_out = ren_n;
    repeat (4) @(negedge clk_in);
    wr_clk_out = dw;
    repeat (skew) @(negedge clk_in);
    rd_clk_out = dr;
    repeat (4) @(negedge clk_in);
    wr_clk_out = 1'b0;
    rd_clk_out = 1'b0;
    repeat (4) @(negedge clk_in);
    // Released lines do not keep their last value
    wr_en_n_out = ~wr_en_n_out;
    wr_data_out = ~wr_data_out;
    rd_en_n_out = ~rd_en_n_out;
  endtask
endmodule // port_side_model

// *** dual_clock_byte_fifo_tb.sv ***
// Self-checking bench of the dual port byte buffer
`timescale 1ns/10ps
`include "byte_fifo_params.svh"
module dual_clock_byte_fifo_tb
  import byte_fifo_pkg::*;
;
  localparam int DEPTH = 16;
  logic        clk;
  logic        rst;
  logic        reset_n;
  logic        oe_n;
  logic        wr_clk;
  logic        wr_en_n;
  byte_type    wr_data;
  logic        rd_clk;
  logic        rd_en_n;
  byte_type    rd_data;
  logic        oe_drv;
  logic        full_n;
  logic        almost_full_n;
  logic        empty_n;
  logic        almost_empty_n;
  logic [12:0] exp_q[$];
  byte_type    ref_q[$];
  byte_type    rdata;
  logic        full_f;
  logic        af_f;
  logic        e_f;
  logic        ae_f;
  logic [31:0] rnd;
  integer      seed;
  int          n_errors;
  int          n_tests;
  int          i;
  event        check_ev;

  dual_clock_byte_fifo #(.DEPTH(DEPTH)) dut
  (
    .CLK_IN             (clk),
    .RST_IN             (rst),
    .RESET_N_IN         (reset_n),
    .WR_CLK_IN          (wr_clk),
    .WR_EN_N_IN         (wr_en_n),
    .WR_DATA_IN         (wr_data),
    .RD_CLK_IN          (rd_clk),
    .RD_EN_N_IN         (rd_en_n),
    .OUT_EN_N_IN        (oe_n),
    .RD_DATA_OUT        (rd_data),
    .RD_DATA_OE_OUT     (oe_drv),
    .FULL_N_OUT         (full_n),
    .ALMOST_FULL_N_OUT  (almost_full_n),
    .EMPTY_N_OUT        (empty_n),
    .ALMOST_EMPTY_N_OUT (almost_empty_n)
  );

  port_side_model u_model
  (
    .clk_in      (clk),
    .wr_clk_out  (wr_clk),
    .wr_en_n_out (wr_en_n),
    .wr_data_out (wr_data),
    .rd_clk_out  (rd_clk),
    .rd_en_n_out (rd_en_n)
  );

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic expect_now();
    exp_q.push_back({!oe_n && !rst, full_f, af_f, e_f, ae_f, rdata});
    -> check_ev;
  endtask

  // One port cycle with the expected outcome worked out first
  task automatic op(input logic dw, input logic dr, input logic wen_n, input logic ren_n,
                    input int skew);
    logic [31:0] r;
    logic        push;
    logic        pop;
    int          fc;
    r = $random(seed);
    @(negedge clk);
    oe_n = r[8];
    push = dw && !wen_n && full_f;
    pop = dr && !ren_n && e_f;
    if (push)
      ref_q.push_back(r[7:0]);
    if (pop)
      rdata = ref_q.pop_front();
    fc = ref_q.size() + ((pop && skew > 0) ? 1 : 0);
    if (dw)
    begin
      full_f = (fc != DEPTH);
      af_f = (fc < DEPTH - `FLAG_MARGIN);
    end
    if (dr)
    begin
      e_f = (ref_q.size() != 0);
      ae_f = (ref_q.size() > `FLAG_MARGIN);
    end
    u_model.port_cycle(dw, dr, wen_n, ren_n, r[7:0], skew);
    expect_now();
  endtask

  // Pin reset or system reset in mid-run
  task automatic do_reset(input logic hard);
    @(negedge clk);
    if (hard)
      rst = 1'b1;
    else
    begin
      oe_n = 1'b1;
      repeat (5) @(negedge clk);
      reset_n = 1'b0;
    end
    ref_q.delete();
    rdata = 8'h00;
    full_f = 1'b1;
    af_f = 1'b1;
    e_f = 1'b0;
    ae_f = 1'b0;
    repeat (6) @(negedge clk);
    expect_now();
    rst = 1'b0;
    reset_n = 1'b1;
    repeat (8) @(negedge clk);
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Result watcher
  initial
  begin
    logic [12:0] want;
    logic [12:0] got;
    forever
    begin
      @(check_ev);
      want = exp_q.pop_front();
      got = {oe_drv, full_n, almost_full_n, empty_n, almost_empty_n, rd_data};
      n_tests++;
      if (got !== want)
      begin
        n_errors++;
        $display("wrong value at %0t ns: got %h expected %h", $time, got, want);
      end
    end
  end

  // Watchdog
  initial
  begin
    #400000;
    n_errors++;
    tally_and_finish();
  end

  initial
  begin
    seed = 32'hf990dbf8;
    n_errors = 0;
    n_tests = 0;
    rst = 1'b1;
    reset_n = 1'b0;
    oe_n = 1'b1;
    rdata = 8'h00;
    full_f = 1'b1;
    af_f = 1'b1;
    e_f = 1'b0;
    ae_f = 1'b0;
    repeat (8) @(negedge clk);
    expect_now();
    rst = 1'b0;
    repeat (4) @(negedge clk);
    reset_n = 1'b1;
    repeat (8) @(negedge clk);
    $display("test power-up reset done");
    op(1'b0, 1'b1, 1'b1, 1'b0, 0);
    for (i = 0; i < 21; i++)
      op(1'b1, i > 2, i % 5 == 4, 1'b1, 0);
    $display("test fill done");
    for (i = 0; i < 24; i++)
      op(i % 3 == 0, 1'b1, 1'b1, i % 4 == 3, 0);
    $display("test drain done");
    for (i = 0; i < 30; i++)
    begin
      rnd = $random(seed);
      op(1'b1, 1'b1, rnd[0], rnd[1] & rnd[2], int'(rnd[4:3]) % 3);
    end
    $display("test shared and skewed clocks done");
    for (i = 0; i < 5; i++)
      op(1'b1, 1'b0, 1'b0, 1'b1, 0);
    do_reset(1'b0);
    op(1'b1, 1'b1, 1'b0, 1'b1, 0);
    op(1'b0, 1'b1, 1'b1, 1'b0, 0);
    $display("test pin reset done");
    for (i = 0; i < 3; i++)
      op(1'b1, 1'b1, 1'b0, 1'b1, 0);
    do_reset(1'b1);
    op(1'b1, 1'b1, 1'b0, 1'b1, 1);
    op(1'b0, 1'b1, 1'b1, 1'b0, 0);
    $display("test system reset done");
    tally_and_finish();
  end
endmodule // dual_clock_byte_fifo_tb
